// File: bench/pwmc_core_props.sv
// port assertions for the pwm core
`timescale 1ns/1ps
`default_nettype none
module pwmc_core_props
  import pwmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PWMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_oe,
  input wire logic irq
);
  // ****
  // apb and pin checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no pready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("read data upper bits set");
  a_irq_held: assert property (irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq)
    else $error("irq dropped without write");
  a_oe_by_write: assert property ($changed(pwm_oe) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("pin enable moved without write");
  a_stop_gpio: assert property (pready && pwrite && paddr == pwmc_addr(PWMC_IDX_CONTROL) && !pwdata[7]
    |-> ##[1:2] pwm_oe == 8'h00)
    else $error("pins not released on stop");
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
  c_wave: cover property ($rose(pwm_out[0]) && pwm_oe[0]);
endmodule // pwmc_core_props
bind pwmc_core pwmc_core_props u_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
`default_nettype wire

// File: bench/pwmc_core_tb.sv
// self-checking bench for the pwm core
`timescale 1ns/1ps
`default_nettype none
module pwmc_core_tb
  import pwmc_pkg::*;
;
  typedef struct {logic [7:0] i; logic [31:0] w; logic [31:0] e;} pwmc_row_t;
  logic clk, resetn, psel, penable, pwrite, clr, pready, pslverr, er, irq;
  logic [PWMC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pwm_out, pwm_oe, pin;
  int hi0, skew, err_count, checked;
  pwmc_row_t rows[7] = '{'{8'hd1, 32'ha5, 32'ha5}, '{8'hd3, 32'h3c, 32'h3c}, '{8'hd4, 32'h34, 32'h34},
    '{8'hd5, 32'h12, 32'h12}, '{8'hd9, 32'h1, 32'h1}, '{8'he3, 32'hbeef, 32'hbeef}, '{8'hd2, 32'h3f, 32'h33}};
  pwmc_core dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
  pwmc_load load (.clk(clk), .clr(clr), .out(pwm_out), .oe(pwm_oe), .pin(pin), .hi0(hi0), .skew(skew));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= pwmc_addr(idx);
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic run(input logic [7:0] ctl, input logic [7:0] pol, input int n, input int e);
    xfer(1, 8'hd2, ctl);
    xfer(1, 8'hd1, pol);
    repeat (24) @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk("high count", e, hi0);
    $display("test wave %h done", ctl);
  endtask
  initial begin
    resetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    clr = 0;
    repeat (8) @(posedge clk);
    resetn <= 1;
    chk("oe", 8'h00, pwm_oe);
    xfer(0, 8'hd2, 0);
    chk("control", 0, rd);
    foreach (rows[k]) begin
      xfer(1, rows[k].i, rows[k].w);
      xfer(0, rows[k].i, 0);
      chk("reg", rows[k].e, rd);
    end
    xfer(0, 8'h10, 0);
    chk("slverr", 1, er);
    $display("test registers done");
    xfer(1, 8'hd4, 3);
    xfer(1, 8'hd5, 0);
    xfer(1, 8'he0, 1);
    xfer(1, 8'hd3, 3);
    run(8'h80, 0, 16, 4);
    chk("oe", 8'h03, pwm_oe);
    chk("irq", 1, irq);
    xfer(0, 8'hd2, 0);
    chk("control", 8'hc0, rd);
    run(8'hc0, 1, 16, 12);
    run(8'hc1, 0, 16, 4);
    run(8'hd0, 0, 32, 8);
    run(8'hf0, 0, 64, 16);
    run(8'hc2, 0, 16, 4);
    chk("pair overlap", 0, skew);
    xfer(1, 8'hd8, 1);
    xfer(1, 8'he0, 2);
    run(8'hc2, 0, 16, 4);
    chk("dead zone", 8, skew);
    xfer(0, 8'hd2, 0);
    chk("control", 8'hc2, rd);
    xfer(1, 8'hd2, 0);
    xfer(1, 8'hd2, 0);
    repeat (3) @(posedge clk);
    chk("oe", 8'h00, pwm_oe);
    chk("irq", 0, irq);
    $display("test stop done");
    print_verdict();
  end
endmodule // pwmc_core_tb
`default_nettype wire

// File: bench/pwmc_load.sv
// load on the pwm pins, pulled down while released
`timescale 1ns/1ps
`default_nettype none
module pwmc_load (
  // clock and window clear
  input wire logic clk,
  input wire logic clr,
  // pins
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  output logic [7:0] pin,
  // measurements
  output int hi0,
  output int skew
);
  assign pin = oe & out;
  always @(posedge clk) begin
    if (clr) begin
      hi0 <= 0;
      skew <= 0;
    end else begin
      hi0 <= hi0 + pin[0];
      skew <= skew + (pin[1] == pin[0]);
    end
  end
endmodule // pwmc_load
`default_nettype wire

// File: design/pwmc_chan.sv
// one duty compare channel with its shadowed duty value
`timescale 1ns/1ps
`default_nettype none
module pwmc_chan
  import pwmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // counter bus
  pwmc_cnt_if.snk cbus,
  // duty value and waveform
  input wire logic [15:0] duty,
  output logic wave
);
  logic [15:0] duty_sh_ff;

  // ************
  // duty shadow
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      duty_sh_ff <= PWMC_RST_WORD;
    end else if (cbus.boundary || !cbus.run) begin
      duty_sh_ff <= duty;
    end
  end

  // high while the count is below the duty value, so duty/(period+1)
  assign wave = cbus.run && (cbus.cnt < duty_sh_ff);
endmodule // pwmc_chan
`default_nettype wire

// File: design/pwmc_cnt_if.sv
// shared counter bus from the timebase to the compare channels
`timescale 1ns/1ps
`default_nettype none
interface pwmc_cnt_if;
  logic [15:0] cnt;
  logic boundary;
  logic run;
  modport src (output cnt, output boundary, output run);
  modport snk (input cnt, input boundary, input run);
endinterface
`default_nettype wire

// File: design/pwmc_core.sv
// eight output multichannel pwm core with apb register slave
`timescale 1ns/1ps
`default_nettype none
module pwmc_core
  import pwmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PWMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm pins
  output logic [7:0] pwm_out,
  output logic [7:0] pwm_oe,
  // interrupt request
  output logic irq
);
  // ************
  // declarations
  // ************
  typedef enum logic [1:0] {
    PWMC_ST_IDLE = 2'b00,
    PWMC_ST_UP = 2'b01,
    PWMC_ST_DOWN = 2'b10
  } pwmc_state_t;

  logic [7:0] pol_ff;
  logic run_ff;
  logic flag_ff;
  logic [1:0] ck_sel_ff;
  logic [1:0] md_ff;
  logic [7:0] pin_en_ff;
  logic [15:0] period_ff;
  logic [7:0] dead_ff;
  logic irq_en_ff;
  logic [15:0] duty_ff [PWMC_CHANNELS];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] pwm_out_ff;
  logic [7:0] pwm_oe_ff;
  logic irq_ff;
  logic [2:0] presc_ff;
  logic tick;
  logic [15:0] cnt_ff;
  logic [15:0] period_sh_ff;
  logic centre_sh_ff;
  pwmc_state_t state_ff;
  pwmc_state_t nxt_state;
  logic [15:0] nxt_cnt;
  logic ovf;
  logic [7:0] wave;
  logic [7:0] wave_d_ff;
  logic [7:0] dz_cnt_ff [PWMC_PAIRS];
  logic [7:0] shaped;
  logic access;
  logic wr_en;
  logic [31:0] rd_word;
  logic rd_hit;

  pwmc_cnt_if cbus ();

  // ************
  // apb access
  // ************
  assign access = psel && penable && !pready_ff;
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      pwmc_addr(PWMC_IDX_POLARITY): rd_word = {24'h000000, pol_ff};
      pwmc_addr(PWMC_IDX_CONTROL): rd_word = {24'h000000, run_ff, flag_ff, ck_sel_ff, 2'b00, md_ff};
      pwmc_addr(PWMC_IDX_PIN_EN): rd_word = {24'h000000, pin_en_ff};
      pwmc_addr(PWMC_IDX_PERIOD_LO): rd_word = {24'h000000, period_ff[7:0]};
      pwmc_addr(PWMC_IDX_PERIOD_HI): rd_word = {24'h000000, period_ff[15:8]};
      pwmc_addr(PWMC_IDX_DEAD_ZONE): rd_word = {24'h000000, dead_ff};
      pwmc_addr(PWMC_IDX_IRQ_EN): rd_word = {31'h00000000, irq_en_ff};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < PWMC_CHANNELS; i++) begin
          if (paddr == pwmc_addr(PWMC_IDX_DUTY0 + 8'(i))) begin
            rd_word = {16'h0000, duty_ff[i]};
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !rd_hit;
      if (access && !pwrite && rd_hit) begin
        prdata_ff <= rd_word;
      end else if (access) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ************
  // configuration registers
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pol_ff <= PWMC_RST_BYTE;
      run_ff <= 1'b0;
      ck_sel_ff <= 2'b00;
      md_ff <= 2'b00;
      pin_en_ff <= PWMC_RST_BYTE;
      period_ff <= PWMC_RST_WORD;
      dead_ff <= PWMC_RST_DEAD;
      irq_en_ff <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        pwmc_addr(PWMC_IDX_POLARITY): pol_ff <= pwdata[7:0];
        pwmc_addr(PWMC_IDX_CONTROL): begin
          run_ff <= pwdata[PWMC_CTL_RUN];
          ck_sel_ff <= pwdata[PWMC_CTL_CK_LSB +: 2];
          md_ff <= pwdata[PWMC_CTL_MD_LSB +: 2];
        end
        pwmc_addr(PWMC_IDX_PIN_EN): pin_en_ff <= pwdata[7:0];
        pwmc_addr(PWMC_IDX_PERIOD_LO): period_ff[7:0] <= pwdata[7:0];
        pwmc_addr(PWMC_IDX_PERIOD_HI): period_ff[15:8] <= pwdata[7:0];
        pwmc_addr(PWMC_IDX_DEAD_ZONE): dead_ff <= pwdata[7:0];
        pwmc_addr(PWMC_IDX_IRQ_EN): irq_en_ff <= pwdata[PWMC_IRQ_EN_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PWMC_CHANNELS; i++) begin
        duty_ff[i] <= PWMC_RST_WORD;
      end
    end else if (wr_en) begin
      for (int i = 0; i < PWMC_CHANNELS; i++) begin
        if (paddr == pwmc_addr(PWMC_IDX_DUTY0 + 8'(i))) begin
          duty_ff[i] <= pwdata[15:0];
        end
      end
    end
  end

  // ************
  // overflow flag
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_ff <= 1'b0;
    end else if (ovf) begin
      flag_ff <= 1'b1;
    end else if (wr_en && paddr == pwmc_addr(PWMC_IDX_CONTROL) && !pwdata[PWMC_CTL_FLAG]) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && irq_en_ff;
    end
  end

  // ************
  // prescaler
  // ************
  // clk stands in for the fast oscillator source of the prescaler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_ff <= 3'h0;
    end else if (!run_ff || tick) begin
      presc_ff <= 3'h0;
    end else begin
      presc_ff <= presc_ff + 3'h1;
    end
  end

  assign tick = run_ff && (presc_ff == ((3'h1 << ck_sel_ff) - 3'h1));

  // ************
  // timebase
  // ************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    ovf = 1'b0;
    case (state_ff)
      PWMC_ST_IDLE: begin
        nxt_cnt = 16'h0000;
        if (run_ff) begin
          nxt_state = PWMC_ST_UP;
        end
      end
      PWMC_ST_UP: begin
        if (tick) begin
          if (cnt_ff == period_sh_ff) begin
            if (centre_sh_ff) begin
              nxt_state = PWMC_ST_DOWN;
            end else begin
              nxt_cnt = 16'h0000;
              ovf = 1'b1;
            end
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
      end
      PWMC_ST_DOWN: begin
        if (tick) begin
          if (cnt_ff == 16'h0000) begin
            nxt_state = PWMC_ST_UP;
            ovf = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
      default: begin
        nxt_state = PWMC_ST_IDLE;
        nxt_cnt = 16'h0000;
      end
    endcase
    if (!run_ff) begin
      nxt_state = PWMC_ST_IDLE;
      nxt_cnt = 16'h0000;
      ovf = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= PWMC_ST_IDLE;
      cnt_ff <= PWMC_RST_WORD;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // period and alignment shadows load at the boundary or while stopped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_sh_ff <= PWMC_RST_WORD;
      centre_sh_ff <= 1'b0;
    end else if (ovf || !run_ff) begin
      period_sh_ff <= period_ff;
      centre_sh_ff <= md_ff[PWMC_MD_CENTRE];
    end
  end

  assign cbus.cnt = cnt_ff;
  assign cbus.boundary = ovf;
  assign cbus.run = run_ff && (state_ff != PWMC_ST_IDLE);

  // ************
  // compare channels
  // ************
  for (genvar g = 0; g < PWMC_CHANNELS; g++) begin : g_chan
    pwmc_chan u_chan (
      .clk(clk),
      .resetn(resetn),
      .cbus(cbus),
      .duty(duty_ff[g]),
      .wave(wave[g])
    );
  end

  // ************
  // dead zone and pairing
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wave_d_ff <= PWMC_RST_BYTE;
      for (int p = 0; p < PWMC_PAIRS; p++) begin
        dz_cnt_ff[p] <= PWMC_RST_DEAD;
      end
    end else begin
      wave_d_ff <= wave;
      for (int p = 0; p < PWMC_PAIRS; p++) begin
        if (wave[2*p] != wave_d_ff[2*p] && dead_ff != 8'h00) begin
          dz_cnt_ff[p] <= dead_ff - 8'h01;
        end else if (dz_cnt_ff[p] != 8'h00) begin
          dz_cnt_ff[p] <= dz_cnt_ff[p] - 8'h01;
        end
      end
    end
  end

  always_comb begin
    shaped = wave;
    if (md_ff[PWMC_MD_COMPL]) begin
      for (int p = 0; p < PWMC_PAIRS; p++) begin
        if ((wave[2*p] != wave_d_ff[2*p] && dead_ff != 8'h00) || dz_cnt_ff[p] != 8'h00) begin
          shaped[2*p] = 1'b0;
          shaped[2*p+1] = 1'b0;
        end else begin
          shaped[2*p] = wave[2*p];
          shaped[2*p+1] = cbus.run && !wave[2*p];
        end
      end
    end
  end

  // ************
  // pin drive
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_out_ff <= PWMC_RST_BYTE;
      pwm_oe_ff <= PWMC_RST_BYTE;
    end else begin
      pwm_out_ff <= shaped ^ pol_ff;
      pwm_oe_ff <= run_ff ? pin_en_ff : 8'h00;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pwm_out = pwm_out_ff;
  assign pwm_oe = pwm_oe_ff;
  assign irq = irq_ff;
endmodule // pwmc_core
`default_nettype wire

// File: design/pwmc_pkg.sv
// constants and helpers shared by the multichannel pwm core
package pwmc_pkg;
  localparam int unsigned PWMC_CHANNELS = 8;
  localparam int unsigned PWMC_PAIRS = 4;
  localparam int unsigned PWMC_CNT_W = 16;
  localparam int unsigned PWMC_ADDR_W = 12;
  // register indices, byte address is four times the index
  localparam logic [7:0] PWMC_IDX_POLARITY = 8'hd1;
  localparam logic [7:0] PWMC_IDX_CONTROL = 8'hd2;
  localparam logic [7:0] PWMC_IDX_PIN_EN = 8'hd3;
  localparam logic [7:0] PWMC_IDX_PERIOD_LO = 8'hd4;
  localparam logic [7:0] PWMC_IDX_PERIOD_HI = 8'hd5;
  localparam logic [7:0] PWMC_IDX_DEAD_ZONE = 8'hd8;
  localparam logic [7:0] PWMC_IDX_IRQ_EN = 8'hd9;
  localparam logic [7:0] PWMC_IDX_DUTY0 = 8'he0;
  // control register fields
  localparam int unsigned PWMC_CTL_RUN = 7;
  localparam int unsigned PWMC_CTL_FLAG = 6;
  localparam int unsigned PWMC_CTL_CK_LSB = 4;
  localparam int unsigned PWMC_CTL_MD_LSB = 0;
  localparam int unsigned PWMC_MD_COMPL = 1;
  localparam int unsigned PWMC_MD_CENTRE = 0;
  localparam int unsigned PWMC_IRQ_EN_BIT = 0;
  // reset values
  localparam logic [7:0] PWMC_RST_BYTE = 8'h00;
  localparam logic [15:0] PWMC_RST_WORD = 16'h0000;
  localparam logic [7:0] PWMC_RST_DEAD = 8'h00;
  // prescaler source clock
  localparam int unsigned PWMC_FAST_OSC_MHZ = 32;

  function automatic logic [PWMC_ADDR_W-1:0] pwmc_addr(input logic [7:0] idx);
    pwmc_addr = {2'h0, idx, 2'h0};
  endfunction
endpackage
